// >>> hdl/rx_cfg_pkg.sv
// constants for the receive/filter/vga configuration register bank
`default_nettype none
package rx_cfg_pkg;
  // ---------------------------------------------------------------
  // serial frame
  // ---------------------------------------------------------------
  localparam int         DATA_W     = 10;
  localparam int         ADDR_W     = 5;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] HDR_BITS   = 5'h06;
  localparam logic       RW_READ    = 1'b1;
  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_RX_FRONT_END_TRIM   = 5'h01;
  localparam logic [4:0] ADDR_LOWPASS_FILTER_CTRL = 5'h02;
  localparam logic [4:0] ADDR_TX_COMMON_MODE_CTRL = 5'h03;
  localparam logic [4:0] ADDR_RX_AMP_OUTPUT_CTRL  = 5'h04;
  localparam logic [4:0] ADDR_RX_AMP_ATTENUATION  = 5'h05;
  localparam logic [4:0] ADDR_SIGNAL_STRENGTH     = 5'h06;
  localparam logic [4:0] ADDR_TEMPERATURE_RESULT  = 5'h07;
  localparam int         CFG_FIRST = 1;
  localparam int         CFG_LAST  = 6;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [9:0] RST_RX_FRONT_END_TRIM   = 10'h002;
  localparam logic [9:0] RST_LOWPASS_FILTER_CTRL = 10'h1f4;
  localparam logic [9:0] RST_TX_COMMON_MODE_CTRL = 10'h1b9;
  localparam logic [9:0] RST_RX_AMP_OUTPUT_CTRL  = 10'h00a;
  localparam logic [9:0] RST_RX_AMP_ATTENUATION  = 10'h080;
  localparam logic [9:0] RST_SIGNAL_STRENGTH     = 10'h006;
  localparam logic [4:0] TEMP_PAD_ZERO           = 5'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int IQ_TRIM_MSB = 9, IQ_TRIM_LSB = 5;
  localparam int LNA_GAIN_MSB = 4, LNA_GAIN_LSB = 2;
  localparam int LNA_TANK_RES_BIT = 1;
  localparam int LNA_TANK_FREQ_BIT = 0;
  localparam int LPF_FINE_MSB = 9, LPF_FINE_LSB = 8;
  localparam int LPF_BW_MSB = 7, LPF_BW_LSB = 4;
  localparam int LPF_MODE_MSB = 3, LPF_MODE_LSB = 2;
  localparam int TX_BUF_EN_BIT = 1;
  localparam int LPF_EN_BIT = 0;
  localparam int TX_CM_MSB = 9, TX_CM_LSB = 7;
  localparam int VGA_CM_MSB = 9, VGA_CM_LSB = 8;
  localparam int VGA_BUF_EN_BIT = 5;
  localparam int VGA_EN_BIT = 4;
  localparam int BB_OUT_SEL_BIT = 5;
  localparam int VGA_ATT_MSB = 4, VGA_ATT_LSB = 0;
  localparam int FMODE_SRC_BIT = 9;
  localparam int RSSI_MODE_BIT = 8;
  localparam int RSSI_PIN_SEL_BIT = 7;
  localparam int RSSI_EN_BIT = 6;
  // ---------------------------------------------------------------
  // filter modes
  // ---------------------------------------------------------------
  localparam logic [1:0] FMODE_RX_CAL = 2'h0;
  localparam logic [1:0] FMODE_RX_LPF = 2'h1;
  localparam logic [1:0] FMODE_TX_LPF = 2'h2;
  localparam logic [1:0] FMODE_TRIM   = 2'h3;
endpackage
`default_nettype wire

// >>> hdl/serial_frame_if.sv
// carrier between the serial frame engine and the register bank
`default_nettype none
interface serial_frame_if;
  logic       wr_strobe;
  logic [4:0] wr_addr;
  logic [9:0] wr_data;
  logic [4:0] rd_addr;
  logic [9:0] rd_data;
  modport engine (
    output wr_strobe,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input  rd_data
  );
  modport bank (
    input  wr_strobe,
    input  wr_addr,
    input  wr_data,
    input  rd_addr,
    output rd_data
  );
endinterface
`default_nettype wire

// >>> hdl/serial_frame_engine.sv
// 4-wire serial frame receiver and readout shifter
`default_nettype none
module serial_frame_engine
  import rx_cfg_pkg::*;
(
  input  wire logic      i_core_clk, // core clock
  input  wire logic      i_rstn,     // async reset, active low
  input  wire logic      i_csn,      // chip select pin, active low
  input  wire logic      i_sclk,     // serial clock pin
  input  wire logic      i_din,      // serial data in pin
  output var  logic      o_dout,     // serial data out pin
  serial_frame_if.engine link        // to register bank
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // pin vectors are {csn, sclk, din}
  typedef struct packed {
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  s3;
    logic [2:0]  filt;
    logic [4:0]  count;
    logic [15:0] shift;
    logic        rw;
    logic        load;
    logic [9:0]  out;
    logic        dout;
    logic        wr;
    logic [4:0]  wa;
    logic [9:0]  wd;
    logic [4:0]  ra;
  } eng_s;

  // stages start at the idle pin levels, so reset release shows no false deselect edge
  localparam eng_s ENG_RESET = '{s1: 3'h4, s2: 3'h4, s3: 3'h4, filt: 3'h4, default: '0};

  eng_s q;
  eng_s next_q;

  // ---------------------------------------------------------------
  // frame logic
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.s1 = {i_csn, i_sclk, i_din};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    // a pin change counts only once stages two and three agree
    next_q.filt = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
    next_q.wr = 1'b0;
    next_q.load = 1'b0;
    if (q.load) begin
      next_q.out = link.rd_data;
    end
    if (q.filt[2] && !next_q.filt[2]) begin
      next_q.count = '0;
      next_q.rw = 1'b0;
    end else if (!next_q.filt[2] && !q.filt[1] && next_q.filt[1] && q.count < FRAME_BITS) begin
      // msb first: flag, five address bits, ten data bits
      next_q.shift = {q.shift[14:0], next_q.filt[0]};
      next_q.count = q.count + 5'h01;
      if (next_q.count == HDR_BITS) begin
        next_q.rw = q.shift[4];
        next_q.ra = {q.shift[3:0], next_q.filt[0]};
        next_q.load = (q.shift[4] == RW_READ);
      end
    end else if (!next_q.filt[2] && q.filt[1] && !next_q.filt[1] && q.rw == RW_READ
                 && q.count >= HDR_BITS && q.count < FRAME_BITS) begin
      // readout changes on falling serial clock edges
      next_q.dout = q.out[9];
      next_q.out = {q.out[8:0], 1'b0};
    end
    if (!q.filt[2] && next_q.filt[2]) begin
      next_q.dout = 1'b0;
      // short frames are dropped, never half committed; bits past the sixteenth are ignored
      if (q.count == FRAME_BITS && q.rw != RW_READ) begin
        next_q.wr = 1'b1;
        next_q.wa = q.shift[14:10];
        next_q.wd = q.shift[9:0];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= ENG_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign o_dout = q.dout;
  assign link.wr_strobe = q.wr;
  assign link.wr_addr = q.wa;
  assign link.wr_data = q.wd;
  assign link.rd_addr = q.ra;
endmodule
`default_nettype wire

// >>> hdl/rx_lpf_vga_config_regs.sv
// configuration register bank for rx front end, lowpass filter, vga and rssi
//
// How it works
// - five-bit lo phase trim, serial select gated
// - three-bit lna gain, serial select gated
// - lna tank resistance bit, resets to one
// - lna tank frequency bit, resets to zero
// - two-bit lowpass cutoff fine tune, reset 01
// - four-bit filter bandwidth, reset 1111
// - filter mode field, used when source selects
// - tx input buffer enable, off in shutdown
// - lowpass filter enable, shutdown overrides
// - two-bit vga output common-mode level
// - vga output buffer and vga enables
// - baseband output source: vga or detector
// - five-bit vga attenuation, serial select gated
// - filter mode source: normal or register
// - rssi in receive gated by highpass input
// - rssi pin routing and rssi enable
// - temperature result in low five bits
// - sixteen-bit msb-first frame, commit on deselect
// - readout shifted on falling serial clock
// - gains from pins unless serial selected
`default_nettype none
module rx_lpf_vga_config_regs
  import rx_cfg_pkg::*;
(
  input  wire logic       i_core_clk,                 // core clock, 20 MHz
  input  wire logic       i_rstn,                     // async reset, active low
  input  wire logic       i_csn,                      // serial chip select, active low
  input  wire logic       i_sclk,                     // serial clock
  input  wire logic       i_din,                      // serial data in
  output var  logic       o_dout,                     // serial data out
  input  wire logic       i_shutdown,                 // shutdown mode pin
  input  wire logic       i_rx_mode,                  // receive mode pin
  input  wire logic       i_tx_mode,                  // transmit mode pin
  input  wire logic       i_rx_highpass_control_input, // receive highpass control
  input  wire logic [2:0] i_ext_lna_gain,             // lna gain pins
  input  wire logic [4:0] i_ext_vga_gain,             // vga gain pins
  input  wire logic [4:0] i_temp_adc,                 // temperature adc result
  input  wire logic [4:0] i_iq_trim_fuse,             // fuse trim word
  input  wire logic       i_iq_trim_serial_sel,       // trim from serial register
  input  wire logic       i_lna_gain_serial_sel,      // lna gain from serial register
  input  wire logic       i_vga_gain_serial_sel,      // vga gain from serial register
  output var  logic [4:0] o_iq_trim,                  // trim dac word
  output var  logic [2:0] o_lna_gain,                 // lna gain code in use
  output var  logic       o_lna_tank_res,             // lna tank resistance tuning
  output var  logic       o_lna_tank_freq,            // lna tank frequency tuning
  output var  logic [1:0] o_lpf_fine_tune,            // cutoff fine tune
  output var  logic [3:0] o_lpf_bandwidth,            // filter bandwidth code
  output var  logic [1:0] o_filter_mode,              // filter mode in use
  output var  logic       o_tx_buffer_en,             // tx input buffer on
  output var  logic       o_lpf_en,                   // lowpass filter on
  output var  logic [2:0] o_tx_common_mode,           // tx common-mode code
  output var  logic [1:0] o_vga_out_cm,               // vga output common mode
  output var  logic       o_vga_out_buf_en,           // vga output buffer on
  output var  logic       o_vga_en,                   // vga on
  output var  logic       o_bb_out_select,            // 1 selects am detector
  output var  logic [4:0] o_vga_atten,                // vga attenuation in use
  output var  logic       o_rssi_en,                  // rssi running
  output var  logic       o_rssi_pin_select           // 1 routes temperature sensor
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       shutdown;
    logic       rx_mode;
    logic       tx_mode;
    logic       rx_highpass_control_input;
    logic [2:0] ext_lna;
    logic [4:0] ext_vga;
    logic [4:0] temp;
  } pin_s;

  typedef struct packed {
    pin_s                      s1;
    pin_s                      s2;
    pin_s                      s3;
    pin_s                      filt;
    logic [6:1][DATA_W-1:0]    cfg;
    logic [4:0]                iq_trim;
    logic [2:0]                lna_gain;
    logic                      lna_tank_res;
    logic                      lna_tank_freq;
    logic [1:0]                lpf_fine;
    logic [3:0]                lpf_bw;
    logic [1:0]                fmode;
    logic                      tx_buf_en;
    logic                      lpf_en;
    logic [2:0]                tx_cm;
    logic [1:0]                vga_cm;
    logic                      vga_buf_en;
    logic                      vga_en;
    logic                      bb_sel;
    logic [4:0]                vga_att;
    logic                      rssi_en;
    logic                      rssi_pin;
  } bank_s;

  localparam logic [6:1][DATA_W-1:0] CFG_RESET = {
    RST_SIGNAL_STRENGTH,
    RST_RX_AMP_ATTENUATION,
    RST_RX_AMP_OUTPUT_CTRL,
    RST_TX_COMMON_MODE_CTRL,
    RST_LOWPASS_FILTER_CTRL,
    RST_RX_FRONT_END_TRIM
  };

  localparam bank_s BANK_RESET = '{cfg: CFG_RESET, default: '0};

  bank_s q;
  bank_s next_q;

  serial_frame_if link ();

  // ---------------------------------------------------------------
  // serial frame engine
  // ---------------------------------------------------------------
  serial_frame_engine u_engine (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_csn      (i_csn),
    .i_sclk     (i_sclk),
    .i_din      (i_din),
    .o_dout     (o_dout),
    .link       (link.engine)
  );

  // ---------------------------------------------------------------
  // readout
  // ---------------------------------------------------------------
  // addresses outside this bank read as zero here
  always_comb begin
    link.rd_data = '0;
    if (link.rd_addr == ADDR_TEMPERATURE_RESULT) begin
      link.rd_data = {TEMP_PAD_ZERO, q.filt.temp};
    end else if (link.rd_addr >= ADDR_RX_FRONT_END_TRIM
                 && link.rd_addr <= ADDR_SIGNAL_STRENGTH) begin
      link.rd_data = q.cfg[link.rd_addr[2:0]];
    end
  end

  // ---------------------------------------------------------------
  // registers and decoded controls
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.s1 = '{
      shutdown: i_shutdown,
      rx_mode:  i_rx_mode,
      tx_mode:  i_tx_mode,
      rx_highpass_control_input:     i_rx_highpass_control_input,
      ext_lna:  i_ext_lna_gain,
      ext_vga:  i_ext_vga_gain,
      temp:     i_temp_adc
    };
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    // per-bit agreement filter; multi-bit buses may settle bit by bit
    next_q.filt = pin_s'((q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3)));

    // commit of a write frame; the result register has no storage
    if (link.wr_strobe) begin
      for (int i = CFG_FIRST; i <= CFG_LAST; i++) begin
        if (link.wr_addr == 5'(i)) begin
          next_q.cfg[i] = link.wr_data;
        end
      end
    end
    // address 7 falls outside the loop, so its writes are dropped

    // front end trim
    next_q.iq_trim = i_iq_trim_serial_sel
      ? q.cfg[1][IQ_TRIM_MSB:IQ_TRIM_LSB]
      : i_iq_trim_fuse;
    next_q.lna_gain = i_lna_gain_serial_sel
      ? q.cfg[1][LNA_GAIN_MSB:LNA_GAIN_LSB]
      : q.filt.ext_lna;
    next_q.lna_tank_res = q.cfg[1][LNA_TANK_RES_BIT];
    next_q.lna_tank_freq = q.cfg[1][LNA_TANK_FREQ_BIT];

    // lowpass filter
    next_q.lpf_fine = q.cfg[2][LPF_FINE_MSB:LPF_FINE_LSB];
    next_q.lpf_bw = q.cfg[2][LPF_BW_MSB:LPF_BW_LSB];
    if (q.cfg[6][FMODE_SRC_BIT]) begin
      next_q.fmode = q.cfg[2][LPF_MODE_MSB:LPF_MODE_LSB];
    end else if (q.filt.tx_mode) begin
      next_q.fmode = FMODE_TX_LPF;
    end else begin
      next_q.fmode = FMODE_RX_LPF;
    end
    next_q.tx_buf_en = q.cfg[2][TX_BUF_EN_BIT] && !q.filt.shutdown;
    next_q.lpf_en = q.cfg[2][LPF_EN_BIT] && !q.filt.shutdown;

    // tx common mode; code 111 is passed through, the host must avoid it
    next_q.tx_cm = q.cfg[3][TX_CM_MSB:TX_CM_LSB];

    // receive vga
    next_q.vga_cm = q.cfg[4][VGA_CM_MSB:VGA_CM_LSB];
    next_q.vga_buf_en = q.cfg[4][VGA_BUF_EN_BIT] && !q.filt.shutdown;
    next_q.vga_en = q.cfg[4][VGA_EN_BIT] && !q.filt.shutdown;
    next_q.bb_sel = q.cfg[5][BB_OUT_SEL_BIT];
    next_q.vga_att = i_vga_gain_serial_sel
      ? q.cfg[5][VGA_ATT_MSB:VGA_ATT_LSB]
      : q.filt.ext_vga;

    // rssi: in receive with the mode bit clear, highpass low turns it off
    next_q.rssi_en = q.cfg[6][RSSI_EN_BIT] && !q.filt.shutdown
      && (!q.filt.rx_mode || q.cfg[6][RSSI_MODE_BIT] || q.filt.rx_highpass_control_input);
    next_q.rssi_pin = q.cfg[6][RSSI_PIN_SEL_BIT];
  end

  // shutdown only gates enables; the stored words survive it
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= BANK_RESET;
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_iq_trim = q.iq_trim;
  assign o_lna_gain = q.lna_gain;
  assign o_lna_tank_res = q.lna_tank_res;
  assign o_lna_tank_freq = q.lna_tank_freq;
  assign o_lpf_fine_tune = q.lpf_fine;
  assign o_lpf_bandwidth = q.lpf_bw;
  assign o_filter_mode = q.fmode;
  assign o_tx_buffer_en = q.tx_buf_en;
  assign o_lpf_en = q.lpf_en;
  assign o_tx_common_mode = q.tx_cm;
  assign o_vga_out_cm = q.vga_cm;
  assign o_vga_out_buf_en = q.vga_buf_en;
  assign o_vga_en = q.vga_en;
  assign o_bb_out_select = q.bb_sel;
  assign o_vga_atten = q.vga_att;
  assign o_rssi_en = q.rssi_en;
  assign o_rssi_pin_select = q.rssi_pin;
endmodule
`default_nettype wire

// >>> tb/rx_cfg_props.sv
// assertion checker bound to the configuration register bank ports
`default_nettype none
module rx_cfg_props (
  input wire logic       i_core_clk,            // core clock
  input wire logic       i_rstn,                // reset, active low
  input wire logic       i_csn,                 // chip select, active low
  input wire logic       i_sclk,                // serial clock
  input wire logic       i_shutdown,            // shutdown pin
  input wire logic [2:0] i_ext_lna_gain,        // lna gain pins
  input wire logic [4:0] i_ext_vga_gain,        // vga gain pins
  input wire logic [4:0] i_iq_trim_fuse,        // fuse trim word
  input wire logic       i_iq_trim_serial_sel,  // trim source
  input wire logic       i_lna_gain_serial_sel, // lna gain source
  input wire logic       i_vga_gain_serial_sel, // vga gain source
  input wire logic       o_dout,                // serial readout
  input wire logic [4:0] o_iq_trim,             // trim in use
  input wire logic [2:0] o_lna_gain,            // lna gain in use
  input wire logic [4:0] o_vga_atten,           // vga attenuation in use
  input wire logic       o_lna_tank_res,        // tank resistance
  input wire logic [3:0] o_lpf_bandwidth,       // filter bandwidth
  input wire logic [2:0] o_tx_common_mode,      // tx common mode
  input wire logic [1:0] o_vga_out_cm,          // vga common mode
  input wire logic       o_tx_buffer_en,        // tx buffer on
  input wire logic       o_lpf_en,              // filter on
  input wire logic       o_vga_out_buf_en,      // vga buffer on
  input wire logic       o_vga_en,              // vga on
  input wire logic       o_rssi_en              // rssi on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // pins pass a synchroniser, so six cycles of a steady level are allowed
  a_shdn_lpf_off: assert property (i_shutdown[*6] |-> !o_lpf_en && !o_tx_buffer_en)
    else $error("filter or tx buffer on in shutdown");
  a_shdn_vga_off: assert property (i_shutdown[*6] |-> !o_vga_en && !o_vga_out_buf_en)
    else $error("vga on in shutdown");
  a_shdn_rssi_off: assert property (i_shutdown[*6] |-> !o_rssi_en)
    else $error("rssi on in shutdown");
  a_lna_pin_path: assert property ((!i_lna_gain_serial_sel && $stable(i_ext_lna_gain))[*6]
    |-> o_lna_gain == i_ext_lna_gain)
    else $error("lna gain not from pins");
  a_vga_pin_path: assert property ((!i_vga_gain_serial_sel && $stable(i_ext_vga_gain))[*6]
    |-> o_vga_atten == i_ext_vga_gain)
    else $error("vga gain not from pins");
  a_trim_fuse_path: assert property ((!i_iq_trim_serial_sel && $stable(i_iq_trim_fuse))[*3]
    |-> o_iq_trim == i_iq_trim_fuse)
    else $error("trim not from fuse word");
  a_dout_idle_low: assert property (i_csn[*8] |-> !o_dout)
    else $error("readout active while deselected");
  a_dout_on_fall: assert property ($changed(o_dout) |-> !$past(i_sclk, 3))
    else $error("readout moved away from a falling edge");
  a_commit_on_deselect: assert property (
    $changed({o_lna_tank_res, o_lpf_bandwidth, o_tx_common_mode, o_vga_out_cm})
    |-> i_csn && $past(i_csn, 5))
    else $error("field changed before deselect");
endmodule
bind rx_lpf_vga_config_regs rx_cfg_props u_props (.*);
`default_nettype wire

// >>> tb/serial_host_model.sv
// behavioural host driving the 4-wire serial link
`default_nettype none
module serial_host_model (
  input  wire logic i_core_clk, // core clock
  input  wire logic i_dout,     // device readout
  output var  logic o_csn,      // chip select, active low
  output var  logic o_sclk,     // serial clock, still outside frames
  output var  logic o_din       // serial data
);
  timeunit 1ns;
  timeprecision 1ps;
  // six core clocks a phase, above the four the device needs
  localparam int HALF = 6;
  initial begin
    o_csn = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask
  // ---------------------------------------------------------------
  // host-side word rules
  // ---------------------------------------------------------------
  function automatic logic [9:0] legal_word(input logic [4:0] a, input logic [9:0] d);
    case (a)
      5'h03: legal_word = {(d[9:7] == 3'h7) ? 3'h6 : d[9:7], 7'h39};
      5'h04: legal_word = {d[9:8], 2'h0, d[5:4], 4'ha};
      5'h05: legal_word = {4'h2, d[5:0]};
      5'h06: legal_word = {d[9:6], 6'h06};
      default: legal_word = d;
    endcase
  endfunction
  // short frames are sent only on purpose, to be dropped
  task automatic frame(input logic rw, input logic [4:0] a, input logic [9:0] d,
                       input int nbits, output logic [9:0] rd);
    logic [15:0] word;
    word = {rw, a, d};
    rd = '0;
    tick(1);
    o_csn = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_din = word[15-i];
      tick(HALF);
      if (i >= 6) rd[15-i] = i_dout;
      o_sclk = 1'b1;
      tick(HALF);
      o_sclk = 1'b0;
    end
    tick(HALF);
    o_csn = 1'b1;
    o_din = ~o_din;
    tick(2 * HALF);
  endtask
endmodule
`default_nettype wire

// >>> tb/rx_lpf_vga_config_regs_tb.sv
// self-checking bench for the configuration register bank
`default_nettype none
module rx_lpf_vga_config_regs_tb
  import rx_cfg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk, i_rstn, i_csn, i_sclk, i_din, o_dout;
  logic        i_shutdown, i_rx_mode, i_tx_mode, i_rx_highpass_control_input;
  logic        i_iq_trim_serial_sel, i_lna_gain_serial_sel, i_vga_gain_serial_sel;
  logic [2:0]  i_ext_lna_gain, o_lna_gain, o_tx_common_mode;
  logic [4:0]  i_ext_vga_gain, i_temp_adc, i_iq_trim_fuse, o_iq_trim, o_vga_atten, a5;
  logic        o_lna_tank_res, o_lna_tank_freq, o_tx_buffer_en, o_lpf_en, o_vga_out_buf_en;
  logic        o_vga_en, o_bb_out_select, o_rssi_en, o_rssi_pin_select;
  logic [1:0]  o_lpf_fine_tune, o_filter_mode, o_vga_out_cm;
  logic [3:0]  o_lpf_bandwidth;
  logic [9:0]  regs [1:6];
  logic [9:0]  rd;
  logic [34:0] obs;
  int          err_count = 0;
  int          n_tests = 0;
  assign obs = {o_iq_trim, o_lna_gain, o_lna_tank_res, o_lna_tank_freq, o_lpf_fine_tune,
                o_lpf_bandwidth, o_filter_mode, o_tx_buffer_en, o_lpf_en, o_tx_common_mode,
                o_vga_out_cm, o_vga_out_buf_en, o_vga_en, o_bb_out_select, o_vga_atten,
                o_rssi_en, o_rssi_pin_select};
  rx_lpf_vga_config_regs dut (.*);
  serial_host_model host (.i_core_clk, .i_dout(o_dout), .o_csn(i_csn), .o_sclk(i_sclk),
                          .o_din(i_din));
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [34:0] expect_outs();
    logic [1:0] mode;
    logic       up;
    mode = regs[6][9] ? regs[2][3:2] : (i_tx_mode ? FMODE_TX_LPF : FMODE_RX_LPF);
    up = !i_shutdown;
    return {i_iq_trim_serial_sel ? regs[1][9:5] : i_iq_trim_fuse,
            i_lna_gain_serial_sel ? regs[1][4:2] : i_ext_lna_gain,
            regs[1][1:0], regs[2][9:4], mode, regs[2][1:0] & {2{up}}, regs[3][9:7],
            regs[4][9:8], regs[4][5:4] & {2{up}}, regs[5][5],
            i_vga_gain_serial_sel ? regs[5][4:0] : i_ext_vga_gain,
            regs[6][6] & up & (!i_rx_mode | regs[6][8] | i_rx_highpass_control_input),
            regs[6][7]};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    host.frame(!RW_READ, a, d, 16, rd);
    if (a >= 5'h01 && a <= 5'h06) regs[a] = d;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [9:0] exp);
    host.frame(RW_READ, a, 10'h000, 16, rd);
    check({25'h0, rd}, {25'h0, exp});
  endtask
  task automatic rand_pins();
    {i_rx_mode, i_tx_mode, i_rx_highpass_control_input, i_iq_trim_serial_sel,
     i_lna_gain_serial_sel, i_vga_gain_serial_sel} = 6'($urandom);
    i_shutdown = ($urandom % 4) == 0;
    {i_ext_lna_gain, i_ext_vga_gain, i_iq_trim_fuse, i_temp_adc} = 18'($urandom);
  endtask
  task automatic load_defaults();
    regs = '{RST_RX_FRONT_END_TRIM, RST_LOWPASS_FILTER_CTRL, RST_TX_COMMON_MODE_CTRL,
             RST_RX_AMP_OUTPUT_CTRL, RST_RX_AMP_ATTENUATION, RST_SIGNAL_STRENGTH};
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {i_shutdown, i_rx_mode, i_tx_mode, i_rx_highpass_control_input} = '0;
    {i_iq_trim_serial_sel, i_lna_gain_serial_sel, i_vga_gain_serial_sel} = '0;
    {i_ext_lna_gain, i_ext_vga_gain, i_temp_adc, i_iq_trim_fuse} = '0;
    i_rstn = 1'b0;
    load_defaults();
    void'($urandom(32'hbf5b));
    tick(4);
    i_rstn = 1'b1;
    tick(8);
    check(obs, expect_outs());
    for (int a = 1; a <= 6; a++) rd_chk(5'(a), regs[a]);
    for (int n = 0; n < 24; n++) begin
      a5 = 5'(1 + $urandom % 6);
      wr(a5, host.legal_word(a5, 10'($urandom)));
      rand_pins();
      tick(8);
      check(obs, expect_outs());
      rd_chk(a5, regs[a5]);
    end
    // every filter mode, both mode sources, each rssi gate case in receive
    i_shutdown = 1'b0;
    i_rx_mode = 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(5'h02, {6'($urandom), 2'(k), 2'h3});
      wr(5'h06, host.legal_word(5'h06, {k[2], k[1], 1'b0, 1'b1, 6'h00}));
      {i_tx_mode, i_rx_highpass_control_input} = {k[1], k[0]};
      tick(8);
      check(obs, expect_outs());
    end
    wr(5'h04, host.legal_word(5'h04, 10'h030));
    i_shutdown = 1'b1;
    tick(8);
    check(obs, expect_outs());
    for (int a = 1; a <= 6; a++) rd_chk(5'(a), regs[a]);
    i_shutdown = 1'b0;
    tick(8);
    check(obs, expect_outs());
    // read-only, unmapped and short frames leave the bank alone
    i_temp_adc = 5'($urandom);
    wr(5'h07, 10'h3ff);
    wr(5'h00, 10'h3ff);
    host.frame(!RW_READ, 5'h01, ~regs[1], 15, rd);
    tick(8);
    check(obs, expect_outs());
    rd_chk(5'h07, {TEMP_PAD_ZERO, i_temp_adc});
    rd_chk(5'h00, 10'h000);
    rd_chk(5'h01, regs[1]);
    // a reset in mid-run brings back every default over the written words
    i_rstn = 1'b0;
    tick(2);
    i_rstn = 1'b1;
    load_defaults();
    tick(8);
    check(obs, expect_outs());
    for (int a = 1; a <= 6; a++) rd_chk(5'(a), regs[a]);
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge i_core_clk);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
